// File: dv/lemc_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the error monitor and control block
module lemc_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic power_down_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic det_err,
    input wire logic corr_err,
    input wire logic prbs_test_en,
    input wire logic prbs_err,
    input wire logic video_lock_in,
    input wire logic video_mode_in,
    input wire logic link_active,
    input wire logic cc_xfer_done,
    input wire logic cc_contention,
    input wire logic lock_out,
    input wire logic relock_req,
    input wire logic err_n_o,
    input wire logic err_n_oe,
    input wire logic reverse_ctrl_chan_en,
    input wire logic cc_ack,
    input wire logic pin0_o,
    input wire logic pin1_o
);
    logic auto_q; // mirror of auto clear enable
    logic blk_q; // mirror of write block
    logic [8:0] hold_q; // cycles the flag stays low with auto clear on
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // follow the two control bits as written, honouring the block
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            auto_q <= 1'b0;
            blk_q <= 1'b0;
        end else if (!power_down_n) begin
            blk_q <= 1'b0;
        end else if (reg_wr && !blk_q) begin
            if (reg_addr == 8'h08) auto_q <= reg_wdata[2];
            if (reg_addr == 8'h04) blk_q <= reg_wdata[7];
        end
    end
    // count how long the flag is held while auto clear may fire
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) hold_q <= 9'h000;
        else if (err_n_oe && auto_q && !prbs_test_en) hold_q <= hold_q + 9'h001;
        else hold_q <= 9'h000;
    end
    a_read_answer: assert property (
        reg_rvalid == $past(reg_rd)) else $error("read answer timing wrong");
    a_ack_contend: assert property (
        cc_ack == (cc_xfer_done && !cc_contention)) else $error("ack despite contention");
    a_drain_only: assert property (
        !err_n_o && !pin0_o && !pin1_o) else $error("open drain pin driven high");
    a_test_flag: assert property (
        (prbs_test_en && prbs_err && !reg_rd) ##1 (prbs_test_en && !reg_rd) |=> err_n_oe)
        else $error("test error did not raise flag");
    a_lock_video: assert property (
        lock_out |-> $past(video_lock_in) && $past(video_mode_in)) else $error("lock without video link");
    a_rev_holdoff: assert property (
        $changed(link_active) |-> ##2 !reverse_ctrl_chan_en [*8]) else $error("reverse channel not held off");
    a_relock_once: assert property (
        relock_req |=> !relock_req ##1 !lock_out) else $error("lock drop wrong");
    a_auto_bound: assert property (
        hold_q <= 9'h0D0) else $error("auto clear too late");
    a_lock_release: assert property (
        $rose(video_lock_in) && !prbs_test_en && !det_err && !corr_err |-> ##[2:3] !err_n_oe)
        else $error("flag kept after lock");
endmodule
bind lemc_ctrl lemc_chk chk_u (.*);
`default_nettype wire

// File: dv/lemc_ser_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side serializer: symbols, error pulses, lock and link state
module lemc_ser_model (
    input wire logic clk_sys,
    output logic sym_valid = 1'b0,
    output logic sym_err = 1'b0,
    output logic det_err = 1'b0,
    output logic corr_err = 1'b0,
    output logic video_lock_in = 1'b1,
    output logic video_mode_in = 1'b1,
    output logic link_active = 1'b0
);
    // n back-to-back error pulses, detected or corrected
    task automatic hits(input int n, input logic c);
        repeat (n) begin
            @(posedge clk_sys);
            det_err <= !c;
            corr_err <= c; // partner has correction, so these pulses are meaningful
        end
        @(posedge clk_sys);
        det_err <= 1'b0;
        corr_err <= 1'b0;
    endtask
    // n symbols, every k-th one with a code error
    task automatic syms(input int n, input int k);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            sym_valid <= 1'b1; // fixed one symbol per clock, rate never steps
            sym_err <= (i % k == 0);
        end
        @(posedge clk_sys);
        sym_valid <= 1'b0;
        sym_err <= 1'b0;
    endtask
    // drop lock, pick link kind, relock
    task automatic relock(input logic m);
        @(posedge clk_sys);
        video_lock_in <= 1'b0;
        video_mode_in <= m;
        repeat (3) @(posedge clk_sys);
        video_lock_in <= 1'b1;
    endtask
    // restart the link after a clock change
    task automatic restart();
        @(posedge clk_sys);
        link_active <= !link_active;
    endtask
endmodule
`default_nettype wire

// File: dv/test_link_error_monitor_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_link_error_monitor_control;
    logic clk_sys = 1'b0, resetn = 1'b0, power_down_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic prbs_test_en = 1'b0, prbs_err = 1'b0, cc_xfer_done = 1'b0, cc_contention = 1'b0;
    logic ext0 = 1'b1, ext1 = 1'b1; // external pin drivers, high = released
    wire logic sym_valid, sym_err, det_err, corr_err, video_lock_in, video_mode_in, link_active;
    wire logic [7:0] reg_rdata;
    wire logic reg_rvalid, lock_out, relock_req, err_n_o, err_n_oe, cc_ack, stagger_disable;
    wire logic forward_ctrl_chan_en, reverse_ctrl_chan_en, pin0_o, pin0_oe, pin1_o, pin1_oe;
    wire logic pin0_i = !pin0_oe && ext0; // pulled-up wire
    wire logic pin1_i = !pin1_oe && ext1;
    int num_errors = 0, n_tests = 0;
    lemc_ctrl #(.REV_BLOCK_CYC(50)) dut_u (.*);
    lemc_ser_model ser_u (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 8'h01);
        chk(reg_rdata, e);
    endtask
    // bounded wait for the flag to reach v, c = cycles spent
    task automatic wait_oe(input logic v, input int lim, output int c);
        c = 0;
        while (err_n_oe !== v && c < lim) begin
            cyc(1);
            c++;
        end
        if (c >= lim) begin
            num_errors++;
            $display("Error %0t: flag wait timed out", $time);
            summarize();
        end
    endtask
    // reset values, unmapped read
    task automatic t_reset();
        logic [7:0] a[9] = '{8'h04, 8'h08, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h12, 8'h13, 8'h20};
        logic [7:0] e[9] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) rx(a[i], e[i]);
    endtask
    // threshold edge, saturation, clear on read
    task automatic t_count();
        wr(8'h0C, 8'h05);
        ser_u.hits(5, 1'b0);
        cyc(3);
        chk(err_n_oe, 8'h00);
        ser_u.hits(300, 1'b0);
        ser_u.hits(2, 1'b1);
        cyc(3);
        chk(err_n_oe, 8'h01);
        rx(8'h10, 8'hFF);
        rx(8'h12, 8'h02);
        cyc(2);
        chk(err_n_oe, 8'h00);
        rx(8'h10, 8'h00);
    endtask
    // auto clear timing, then test mode
    task automatic t_auto();
        int c;
        wr(8'h08, 8'h04);
        rx(8'h08, 8'h04);
        ser_u.hits(1, 1'b1);
        wait_oe(1'b1, 10, c);
        wait_oe(1'b0, 400, c);
        chk(c >= 195 && c <= 205, 8'h01);
        rx(8'h12, 8'h00);
        @(posedge clk_sys);
        prbs_test_en <= 1'b1;
        ser_u.hits(3, 1'b1);
        rx(8'h12, 8'h00);
        chk(err_n_oe, 8'h00);
        @(posedge clk_sys);
        prbs_err <= 1'b1;
        @(posedge clk_sys);
        prbs_err <= 1'b0;
        cyc(300);
        chk(err_n_oe, 8'h01);
        rx(8'h13, 8'h01);
        cyc(2);
        chk(err_n_oe, 8'h00);
        @(posedge clk_sys);
        prbs_test_en <= 1'b0;
        wr(8'h08, 8'h00);
    endtask
    // lock loss freezes counting, lock rise clears
    task automatic t_lock();
        ser_u.hits(2, 1'b0);
        ser_u.syms(16, 4);
        cyc(2);
        chk(lock_out, 8'h00);
        ser_u.hits(3, 1'b1);
        rx(8'h12, 8'h00);
        ser_u.relock(1'b0);
        cyc(3);
        chk(lock_out, 8'h00);
        ser_u.relock(1'b1);
        cyc(3);
        chk(lock_out, 8'h01);
        rx(8'h10, 8'h00);
    endtask
    // acknowledge, channel enables, reverse hold-off
    task automatic t_chan();
        @(posedge clk_sys);
        cc_xfer_done <= 1'b1;
        cc_contention <= 1'b1;
        cyc(0);
        chk(cc_ack, 8'h00);
        @(posedge clk_sys);
        cc_contention <= 1'b0;
        cyc(0);
        chk(cc_ack, 8'h01);
        @(posedge clk_sys);
        cc_xfer_done <= 1'b0;
        wr(8'h04, 8'h00);
        cyc(1);
        chk({forward_ctrl_chan_en, reverse_ctrl_chan_en}, 8'h00);
        wr(8'h04, 8'h03);
        cyc(1);
        chk({forward_ctrl_chan_en, reverse_ctrl_chan_en}, 8'h03);
        ser_u.restart();
        cyc(40);
        chk(reverse_ctrl_chan_en, 8'h00);
        cyc(20);
        chk(reverse_ctrl_chan_en, 8'h01);
    endtask
    // open-drain pins and their input bits
    task automatic t_pins();
        wr(8'h0E, 8'h00);
        cyc(3);
        chk({pin1_oe, pin0_oe}, 8'h03);
        rx(8'h0E, 8'h00);
        wr(8'h0E, 8'h0A);
        ext1 <= 1'b0;
        cyc(3);
        chk({pin1_oe, pin0_oe}, 8'h00);
        rx(8'h0E, 8'h0B);
        @(posedge clk_sys);
        ext1 <= 1'b1;
    endtask
    // addresses, stagger, write block until power down
    task automatic t_block();
        wr(8'h00, 8'hA5);
        rx(8'h00, 8'hA5);
        wr(8'h01, 8'h5A);
        rx(8'h01, 8'h5A);
        wr(8'h08, 8'h08);
        cyc(1);
        chk(stagger_disable, 8'h01);
        wr(8'h04, 8'h83);
        wr(8'h08, 8'h00);
        wr(8'h01, 8'h11);
        cyc(1);
        chk(stagger_disable, 8'h01);
        rx(8'h01, 8'h5A);
        @(posedge clk_sys);
        power_down_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        power_down_n <= 1'b1;
        wr(8'h08, 8'h00);
        cyc(1);
        chk(stagger_disable, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_count();
        t_auto();
        t_lock();
        t_chan();
        t_pins();
        t_block();
        summarize();
    end
endmodule
`default_nettype wire

// File: logic/lemc_ctrl.v
// What this block does
// - separate 8-bit detected and corrected error counters
// - error rate at least quarter drops lock, relocks
// - detected and corrected counters clear on lock, read, auto clear; test counter clears on read only
// - test mode counts test errors, zeroes detected and corrected counters
// - error flag low above threshold or on test error
// - error flag released once both counts are at or below threshold (test mode: test count clear)
// - default clearing by reading error registers or on lock rise
// - auto clear fires one microsecond after flag
// - auto clear off at reset, enabled by bit
// - no auto clear during test mode
// - two bits enable forward and reverse channels
// - no arbitration, no acknowledge on contention
// - reverse channel blocked 350us after link change
// - lock output only for video link
// - write block holds until power down
// - pin output bit zero pulls pin low
// - pin inputs always readable beside output bits
// - stagger disable bit removes output delays
`timescale 1ns/1ps
`default_nettype none
`include "lemc_regs.vh"

module lemc_ctrl #(
    parameter W = 8,
    parameter LOSS_WIN = 16,
    parameter REV_BLOCK_CYC = `LEMC_REV_BLOCK_US * `LEMC_CLK_MHZ,
    parameter [7:0] SER_ADDR_RST = 8'h40,
    parameter [7:0] DES_ADDR_RST = 8'h48
) (
    input wire clk_sys,
    input wire resetn,
    input wire power_down_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire sym_valid,
    input wire sym_err,
    input wire det_err,
    input wire corr_err,
    input wire prbs_test_en,
    input wire prbs_err,
    input wire video_lock_in,
    input wire video_mode_in,
    input wire link_active,
    input wire cc_xfer_done,
    input wire cc_contention,
    input wire pin0_i,
    input wire pin1_i,
    output reg lock_out,
    output reg relock_req,
    output wire err_n_o,
    output wire err_n_oe,
    output wire forward_ctrl_chan_en,
    output wire reverse_ctrl_chan_en,
    output wire cc_ack,
    output wire pin0_o,
    output wire pin0_oe,
    output wire pin1_o,
    output wire pin1_oe,
    output wire stagger_disable
);
    // derived cycle counts, worked out at full width then cut to counter size
    localparam [31:0] AUTO_CLR_W = (`LEMC_AUTO_CLR_NS * `LEMC_CLK_MHZ) / 1000 - 1;
    localparam [31:0] REV_LOAD_W = REV_BLOCK_CYC;
    localparam [31:0] LOSS_LIMIT_W = LOSS_WIN / 4;
    localparam [31:0] WIN_LAST_W = LOSS_WIN - 1;
    localparam [7:0] AUTO_CLR_LAST = AUTO_CLR_W[7:0];
    localparam [16:0] REV_LOAD = REV_LOAD_W[16:0];
    localparam [4:0] LOSS_LIMIT = LOSS_LIMIT_W[4:0];
    localparam [4:0] WIN_LAST = WIN_LAST_W[4:0];

    // rate monitor states
    localparam ST_TRACK = 2'b01;
    localparam ST_LOST = 2'b10;

    // software registers
    reg [7:0] ser_addr_q; // serializer device address copy
    reg [7:0] des_addr_q; // own device address
    reg fwd_en_q;
    reg rev_en_q;
    reg cfg_block_q; // write block, sticky
    reg auto_en_q;
    reg stag_dis_q;
    reg [7:0] det_thr_q;
    reg [7:0] corr_thr_q;
    reg pin0_out_q;
    reg pin1_out_q;
    reg pin0_in_q;
    reg pin1_in_q;

    // monitor state
    reg [1:0] mon_q;
    reg [4:0] win_cnt_q; // symbols seen in window
    reg [4:0] win_err_q; // errors seen in window
    reg lock_prev_q;
    reg link_prev_q;
    reg err_flag_q;
    reg [7:0] auto_cnt_q;
    reg [16:0] rev_block_q;

    wire [W-1:0] det_cnt;
    wire [W-1:0] corr_cnt;
    wire [W-1:0] prbs_cnt;

    // read address decode
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_ok = reg_wr && !cfg_block_q;
    wire lock_rise = video_lock_in && !lock_prev_q;
    wire frozen = (mon_q == ST_LOST);
    wire auto_fire = auto_en_q && !prbs_test_en && err_flag_q && (auto_cnt_q == AUTO_CLR_LAST);
    wire clr_det = lock_rise || auto_fire || (reg_rd && hit(reg_addr, `LEMC_OFS_DET_CNT));
    wire clr_corr = lock_rise || auto_fire || (reg_rd && hit(reg_addr, `LEMC_OFS_CORR_CNT));
    wire clr_prbs = reg_rd && hit(reg_addr, `LEMC_OFS_PRBS_CNT);
    wire flag_cond = prbs_test_en ? (prbs_cnt != {W{1'b0}}) :
        ((det_cnt > det_thr_q) || (corr_cnt > corr_thr_q));
    wire win_err_nx = sym_valid && sym_err;

    // detected error counter
    lemc_sat_cnt #(.W(W)) u_det (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inc(det_err),
        .clr(clr_det),
        .hold_zero(prbs_test_en),
        .freeze(frozen),
        .cnt_q(det_cnt)
    );

    // corrected error counter
    lemc_sat_cnt #(.W(W)) u_corr (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inc(corr_err),
        .clr(clr_corr),
        .hold_zero(prbs_test_en),
        .freeze(frozen),
        .cnt_q(corr_cnt)
    );

    // test error counter, only in test mode
    lemc_sat_cnt #(.W(W)) u_prbs (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inc(prbs_err && prbs_test_en),
        .clr(clr_prbs),
        .hold_zero(1'b0),
        .freeze(1'b0),
        .cnt_q(prbs_cnt)
    );

    // register writes and config block
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ser_addr_q <= SER_ADDR_RST; // arbitrary default address
            des_addr_q <= DES_ADDR_RST; // arbitrary default address
            fwd_en_q <= 1'b1;
            rev_en_q <= 1'b1;
            cfg_block_q <= 1'b0;
            auto_en_q <= 1'b0;
            stag_dis_q <= 1'b0;
            det_thr_q <= `LEMC_RST_THR;
            corr_thr_q <= `LEMC_RST_THR;
            pin0_out_q <= `LEMC_RST_PIN_OUT;
            pin1_out_q <= `LEMC_RST_PIN_OUT;
        end else if (!power_down_n) begin
            // power down lifts the write block
            cfg_block_q <= 1'b0;
        end else if (wr_ok) begin
            case (reg_addr)
                `LEMC_OFS_SER_ADDR: begin
                    ser_addr_q <= reg_wdata;
                end
                `LEMC_OFS_DES_ADDR: begin
                    des_addr_q <= reg_wdata;
                end
                `LEMC_OFS_CC_EN: begin
                    fwd_en_q <= reg_wdata[`LEMC_BIT_FWD_CC];
                    rev_en_q <= reg_wdata[`LEMC_BIT_REV_CC];
                    cfg_block_q <= reg_wdata[`LEMC_BIT_CFG_BLOCK];
                end
                `LEMC_OFS_ERR_CTL: begin
                    auto_en_q <= reg_wdata[`LEMC_BIT_AUTO_CLR];
                    stag_dis_q <= reg_wdata[`LEMC_BIT_STAG_DIS];
                end
                `LEMC_OFS_DET_THR: begin
                    det_thr_q <= reg_wdata;
                end
                `LEMC_OFS_CORR_THR: begin
                    corr_thr_q <= reg_wdata;
                end
                `LEMC_OFS_PIN: begin
                    pin0_out_q <= reg_wdata[`LEMC_BIT_PIN0_OUT];
                    pin1_out_q <= reg_wdata[`LEMC_BIT_PIN1_OUT];
                end
                default: begin
                    // unmapped or read-only: ignored
                end
            endcase
        end
    end

    // read data path, one cycle latency
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `LEMC_OFS_SER_ADDR: reg_rdata <= ser_addr_q;
                    `LEMC_OFS_DES_ADDR: reg_rdata <= des_addr_q;
                    `LEMC_OFS_CC_EN: reg_rdata <= {cfg_block_q, 5'h00, fwd_en_q, rev_en_q};
                    `LEMC_OFS_ERR_CTL: reg_rdata <= {4'h0, stag_dis_q, auto_en_q, 2'h0};
                    `LEMC_OFS_DET_THR: reg_rdata <= det_thr_q;
                    `LEMC_OFS_CORR_THR: reg_rdata <= corr_thr_q;
                    `LEMC_OFS_PIN: reg_rdata <= {4'h0, pin1_out_q, pin1_in_q, pin0_out_q, pin0_in_q};
                    `LEMC_OFS_DET_CNT: reg_rdata <= det_cnt;
                    `LEMC_OFS_CORR_CNT: reg_rdata <= corr_cnt;
                    `LEMC_OFS_PRBS_CNT: reg_rdata <= prbs_cnt;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // pin input sampling, buffers always on
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin0_in_q <= 1'b1;
            pin1_in_q <= 1'b1;
        end else begin
            pin0_in_q <= pin0_i;
            pin1_in_q <= pin1_i;
        end
    end

    // symbol error rate monitor
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mon_q <= ST_TRACK;
            win_cnt_q <= 5'h00;
            win_err_q <= 5'h00;
            relock_req <= 1'b0;
        end else begin
            relock_req <= 1'b0;
            case (mon_q)
                ST_TRACK: begin
                    if (sym_valid) begin
                        if (win_err_q + {4'h0, win_err_nx} >= LOSS_LIMIT) begin
                            // quarter of window in error: drop and relock
                            mon_q <= ST_LOST;
                            relock_req <= 1'b1;
                            win_cnt_q <= 5'h00;
                            win_err_q <= 5'h00;
                        end else if (win_cnt_q == WIN_LAST) begin
                            win_cnt_q <= 5'h00;
                            win_err_q <= 5'h00;
                        end else begin
                            win_cnt_q <= win_cnt_q + 5'h01;
                            win_err_q <= win_err_q + {4'h0, win_err_nx};
                        end
                    end
                end
                ST_LOST: begin
                    // counting frozen until the receiver relocks
                    if (lock_rise) begin
                        mon_q <= ST_TRACK;
                    end
                end
                default: begin
                    mon_q <= ST_TRACK;
                end
            endcase
        end
    end

    // lock output and edge history
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lock_prev_q <= 1'b0;
            link_prev_q <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            lock_prev_q <= video_lock_in;
            link_prev_q <= link_active;
            lock_out <= video_lock_in && video_mode_in && !frozen;
        end
    end

    // error flag, follows counts so it releases once flag_cond is false or auto clear fires
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            err_flag_q <= 1'b0;
        end else begin
            err_flag_q <= flag_cond && !auto_fire;
        end
    end

    // auto clear delay from flag assertion
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            auto_cnt_q <= 8'h00;
        end else if (!err_flag_q || !auto_en_q || prbs_test_en || auto_fire) begin
            auto_cnt_q <= 8'h00;
        end else begin
            auto_cnt_q <= auto_cnt_q + 8'h01;
        end
    end

    // reverse channel hold-off after link start or stop
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rev_block_q <= 17'h00000;
        end else if (link_active != link_prev_q) begin
            rev_block_q <= REV_LOAD;
        end else if (rev_block_q != 17'h00000) begin
            rev_block_q <= rev_block_q - 17'h00001;
        end
    end

    // open-drain error flag: drive low while set
    assign err_n_o = 1'b0;
    assign err_n_oe = err_flag_q;
    assign forward_ctrl_chan_en = fwd_en_q;
    assign reverse_ctrl_chan_en = rev_en_q && (rev_block_q == 17'h00000);
    // acknowledge only clean transfers; no arbitration here
    assign cc_ack = cc_xfer_done && !cc_contention;
    assign pin0_o = 1'b0;
    assign pin0_oe = !pin0_out_q;
    assign pin1_o = 1'b0;
    assign pin1_oe = !pin1_out_q;
    assign stagger_disable = stag_dis_q;
endmodule

`default_nettype wire

// File: logic/lemc_regs.vh
`ifndef LEMC_REGS_VH
`define LEMC_REGS_VH

// register offsets
`define LEMC_OFS_SER_ADDR 8'h00
`define LEMC_OFS_DES_ADDR 8'h01
`define LEMC_OFS_CC_EN 8'h04
`define LEMC_OFS_ERR_CTL 8'h08
`define LEMC_OFS_DET_THR 8'h0C
`define LEMC_OFS_CORR_THR 8'h0D
`define LEMC_OFS_PIN 8'h0E
`define LEMC_OFS_DET_CNT 8'h10
`define LEMC_OFS_CORR_CNT 8'h12
`define LEMC_OFS_PRBS_CNT 8'h13

// field positions
`define LEMC_BIT_REV_CC 0
`define LEMC_BIT_FWD_CC 1
`define LEMC_BIT_CFG_BLOCK 7
`define LEMC_BIT_AUTO_CLR 2
`define LEMC_BIT_STAG_DIS 3
`define LEMC_BIT_PIN0_IN 0
`define LEMC_BIT_PIN0_OUT 1
`define LEMC_BIT_PIN1_IN 2
`define LEMC_BIT_PIN1_OUT 3

// reset values
`define LEMC_RST_CC_EN 8'h03
`define LEMC_RST_ERR_CTL 8'h00
`define LEMC_RST_THR 8'h00
`define LEMC_RST_PIN_OUT 1'b1

// timing
`define LEMC_CLK_MHZ 200
`define LEMC_AUTO_CLR_NS 1000
`define LEMC_REV_BLOCK_US 350

`endif

// File: logic/lemc_sat_cnt.v
`timescale 1ns/1ps
`default_nettype none

// saturating counter with clear and hold-at-zero
module lemc_sat_cnt #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire resetn,
    input wire inc,
    input wire clr,
    input wire hold_zero,
    input wire freeze,
    output reg [W-1:0] cnt_q
);
    reg [W-1:0] cnt_d;

    // next count: zero while held, clear with a same-cycle event restarts at one unless frozen
    always @* begin
        cnt_d = cnt_q;
        if (hold_zero) begin
            cnt_d = {W{1'b0}};
        end else if (clr) begin
            cnt_d = (inc && !freeze) ? {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
        end else if (inc && !freeze && cnt_q != {W{1'b1}}) begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // count register
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

`default_nettype wire
